/* File: spi_host_model.sv */
// Purpose: behavioural serial host for the port
// Assumes: pins move just after clk_i rising edges
// Notes: half_i is the serial half period in clk_i cycles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	// control and return line
	input wire logic		clk_i,
	input wire logic		go_i,
	input wire logic [1:0]	mode_i,
	input wire logic [15:0]	word_i,
	input wire logic [4:0]	nbits_i,
	input wire logic [3:0]	half_i,
	input wire logic		dev_data_i,
	input wire logic		dev_oe_n_i,
	// pins and results
	output logic		sclk_o,
	output logic		cs_n_o,
	output logic		data_o,
	output logic [15:0]	got_o,
	output logic		done_o
);
	logic		last = 1'h0;
	logic [15:0]	sh;
	// released return line reads as the inverse of its last level
	wire		line = dev_oe_n_i ? ~last : dev_data_i;
	always @(posedge clk_i) if (!dev_oe_n_i) last <= dev_data_i;
	initial begin
		{sclk_o, cs_n_o, data_o, done_o, got_o} = 20'h40000;
		forever begin
			@(posedge clk_i);
			done_o <= 1'h0;
			if (!go_i) begin
				// idle: clock parked, host line wanders
				sclk_o <= mode_i[1];
				data_o <= ~data_o;
			end else begin
				sh = word_i;
				{cs_n_o, data_o, got_o} <= {1'h0, sh[15], 16'h0000};
				repeat (4 * half_i) @(posedge clk_i);
				for (int k = 0; k < 2 * nbits_i; k++) begin
					sclk_o <= ~sclk_o;
					if (k % 2 != mode_i[0]) begin
						got_o <= {got_o[14:0], line};
						sh = sh << 1;
					end else begin
						data_o <= sh[15];
					end
					repeat (half_i) @(posedge clk_i);
				end
				{cs_n_o, done_o} <= 2'h3;
				repeat (4) @(posedge clk_i);
			end
		end
	end
endmodule
`default_nettype wire

/* File: spi_periph_pkg.sv */
// Purpose: shared constants and carriers of the serial peripheral port
// Assumes: system clock at 100 MHz, also used as the internal bus clock
// Notes:   field positions refer to the two configuration words given as ports
package spi_periph_pkg;

	// ****************************************
	// configuration word layout
	// ****************************************
	localparam int unsigned CTRL_CONTROLLER_BIT = 0;
	localparam int unsigned FMT_PHASE_BIT       = 16;
	localparam int unsigned FMT_POLARITY_BIT    = 17;
	localparam int unsigned FMT_PRESCALE_LSB    = 8;
	localparam int unsigned FMT_PRESCALE_MSB    = 15;
	localparam int unsigned REG_WIDTH           = 32;

	// ****************************************
	// word framing
	// ****************************************
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned CNT_WIDTH = 5;
	localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_WIDTH-1:0] CNT_ONE  = 5'h01;
	localparam logic [CNT_WIDTH-1:0] CNT_FULL = 5'h10;
	localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned MIN_SCLK_NS      = 25;
	localparam int unsigned MIN_SCLK_CYC_INT = (MIN_SCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PER_WIDTH        = 9;
	localparam logic [PER_WIDTH-1:0] MIN_SCLK_CYC = PER_WIDTH'(MIN_SCLK_CYC_INT);
	localparam logic [PER_WIDTH-1:0] PER_ZERO     = 9'h000;
	localparam logic [PER_WIDTH-1:0] PER_ONE      = 9'h001;
	localparam logic [PER_WIDTH-1:0] PER_MAX      = 9'h1FF;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic data;
	} pins_s;

	typedef struct packed {
		logic       controller;
		logic       phase;
		logic       polarity;
		logic [7:0] prescale;
	} cfg_s;

	typedef struct packed {
		logic sclk_rise;
		logic sclk_fall;
		logic cs_fall;
		logic cs_rise;
	} edges_s;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SHIFT  = 2'b01,
		ST_LOCKED = 2'b10
	} state_e;

endpackage

/* File: spi_peripheral_port.sv */
// Purpose: serial peripheral port, 16-bit words framed by chip select
// Assumes: pins synchronous to clk_i; clk_i is the internal bus clock
// Notes:   transmit word is taken at the falling edge of chip select
`timescale 1ns/1ps
`default_nettype none
module spi_peripheral_port
	import spi_periph_pkg::*;
(
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_n_i,
	// configuration words
	input  wire logic [REG_WIDTH-1:0] global_control_reg_i,
	input  wire logic [REG_WIDTH-1:0] format_reg_i,
	// serial pins
	input  wire logic                 serial_clock_in_i,
	input  wire logic                 chip_select_n_i,
	input  wire logic                 host_to_dev_data_i,
	output logic                      dev_to_host_data_o,
	output logic                      dev_to_host_data_oe_n_o,
	// internal word side
	input  wire logic [WORD_BITS-1:0] tx_word_i,
	output logic                      tx_taken_o,
	output logic [WORD_BITS-1:0]      rx_word_o,
	output logic                      rx_valid_o,
	// status
	output logic                      busy_o,
	output logic                      frame_error_o,
	output logic                      period_error_o
);

	// ****************************************
	// configuration decode
	// ****************************************
	wire cfg_s cfg;
	assign cfg.controller = global_control_reg_i[CTRL_CONTROLLER_BIT];
	assign cfg.phase      = format_reg_i[FMT_PHASE_BIT];
	assign cfg.polarity   = format_reg_i[FMT_POLARITY_BIT];
	assign cfg.prescale   = format_reg_i[FMT_PRESCALE_MSB:FMT_PRESCALE_LSB];

	wire logic enabled = ~cfg.controller;
	wire logic same_sense = ~(cfg.polarity ^ cfg.phase);

	// ****************************************
	// pin sampling
	// ****************************************
	wire pins_s pins;
	pins_s      now;
	edges_s     edges;

	assign pins.sclk = serial_clock_in_i;
	assign pins.cs_n = chip_select_n_i;
	assign pins.data = host_to_dev_data_i;

	spi_pin_sampler u_sampler (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pins_i  (pins),
		.now_o   (now),
		.edges_o (edges)
	);

	// ****************************************
	// edge selection
	// ****************************************
	// rising launch when polarity equals phase
	wire logic launch_edge = same_sense ? edges.sclk_rise : edges.sclk_fall;
	// falling capture when polarity equals phase
	wire logic capture_edge = same_sense ? edges.sclk_fall : edges.sclk_rise;

	// ****************************************
	// frame state
	// ****************************************
	state_e               state_q;
	state_e               state_d;
	logic [CNT_WIDTH-1:0] cnt_q;
	logic [WORD_BITS-1:0] rx_shift_q;
	logic [WORD_BITS-1:0] tx_shift_q;

	wire logic selected = ~now.cs_n;
	// clocks only count while selected in ST_SHIFT, which is left one cycle after enable drops
	wire logic in_frame = (state_q == ST_SHIFT) & selected;
	wire logic do_capture = in_frame & capture_edge & (cnt_q != CNT_FULL);
	wire logic do_launch = in_frame & launch_edge;
	// word taken at select fall, ahead of the first clock edge
	wire logic start = enabled & edges.cs_fall;
	wire logic stop = (state_q == ST_SHIFT) & edges.cs_rise;
	// sixteen or more bits make a valid word; bits past the sixteenth only flag overrun
	wire logic word_ok = stop & (cnt_q == CNT_FULL);
	// select pulse not enclosing sixteen bits
	wire logic word_bad = stop & (cnt_q != CNT_FULL);
	wire logic overrun = in_frame & capture_edge & (cnt_q == CNT_FULL);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_SHIFT;
				end else if (selected) begin
					state_d = ST_LOCKED;
				end
			end
			ST_SHIFT: begin
				if (!selected || !enabled) begin
					state_d = ST_IDLE;
				end
			end
			ST_LOCKED: begin
				if (!selected) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ****************************************
	// shift registers and bit counter
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q      <= CNT_ZERO;
			rx_shift_q <= WORD_ZERO;
			tx_shift_q <= WORD_ZERO;
		end else if (start) begin
			cnt_q      <= CNT_ZERO;
			tx_shift_q <= tx_word_i;
		end else if (!in_frame) begin
			cnt_q <= CNT_ZERO;
		end else if (do_capture) begin
			cnt_q      <= cnt_q + CNT_ONE;
			rx_shift_q <= {rx_shift_q[WORD_BITS-2:0], now.data};
			tx_shift_q <= {tx_shift_q[WORD_BITS-2:0], 1'b0};
		end
	end

	// ****************************************
	// return data line
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dev_to_host_data_o      <= 1'b0;
			dev_to_host_data_oe_n_o <= 1'b1;
		end else if (start) begin
			dev_to_host_data_o      <= tx_word_i[WORD_BITS-1];
			dev_to_host_data_oe_n_o <= 1'b0;
		end else if (!in_frame) begin
			dev_to_host_data_o      <= 1'b0;
			dev_to_host_data_oe_n_o <= 1'b1;
		end else if (do_launch) begin
			dev_to_host_data_o <= tx_shift_q[WORD_BITS-1];
		end
	end

	// ****************************************
	// word delivery and status
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_word_o     <= WORD_ZERO;
			rx_valid_o    <= 1'b0;
			tx_taken_o    <= 1'b0;
			frame_error_o <= 1'b0;
			busy_o        <= 1'b0;
		end else begin
			if (word_ok) begin
				rx_word_o <= rx_shift_q;
			end
			rx_valid_o    <= word_ok;
			tx_taken_o    <= start;
			frame_error_o <= word_bad | overrun;
			busy_o        <= (state_d == ST_SHIFT);
		end
	end

	// ****************************************
	// serial clock period check
	// ****************************************
	logic [PER_WIDTH-1:0] per_q;
	logic                 seen_q;

	wire logic [PER_WIDTH-1:0] ps_cycles = {1'b0, cfg.prescale} + PER_ONE;
	wire logic [PER_WIDTH-1:0] need_cyc = (ps_cycles > MIN_SCLK_CYC) ? ps_cycles : MIN_SCLK_CYC;
	wire logic [PER_WIDTH-1:0] elapsed = (per_q == PER_MAX) ? PER_MAX : per_q + PER_ONE;
	// period between capture edges too short
	wire logic too_fast = in_frame & capture_edge & seen_q & (elapsed < need_cyc);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_q          <= PER_ZERO;
			seen_q         <= 1'b0;
			period_error_o <= 1'b0;
		end else begin
			if (!in_frame) begin
				per_q  <= PER_ZERO;
				seen_q <= 1'b0;
			end else if (capture_edge) begin
				per_q  <= PER_ZERO;
				seen_q <= 1'b1;
			end else if (per_q != PER_MAX) begin
				per_q <= per_q + PER_ONE;
			end
			period_error_o <= too_fast;
		end
	end

endmodule
`default_nettype wire

/* File: spi_peripheral_port_properties.sv */
// Purpose: port checks of the serial peripheral port
// Assumes: one clock domain
// Notes: bound to every port instance
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker
	import spi_periph_pkg::*;
(
	// clock and reset
	input wire logic			clk_i,
	input wire logic			rst_n_i,
	// watched ports
	input wire logic [REG_WIDTH-1:0]	global_control_reg_i,
	input wire logic [REG_WIDTH-1:0]	format_reg_i,
	input wire logic			serial_clock_in_i,
	input wire logic			chip_select_n_i,
	input wire logic [WORD_BITS-1:0]	tx_word_i,
	input wire logic			dev_to_host_data_o,
	input wire logic			dev_to_host_data_oe_n_o,
	input wire logic			tx_taken_o,
	input wire logic [WORD_BITS-1:0]	rx_word_o,
	input wire logic			rx_valid_o,
	input wire logic			frame_error_o,
	input wire logic			busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	logic		sclk_q;
	logic [3:0]	launch_q;
	wire		cs_n = chip_select_n_i;
	wire		oe_n = dev_to_host_data_oe_n_o;
	wire		dq = dev_to_host_data_o;
	wire		ctl = global_control_reg_i[CTRL_CONTROLLER_BIT];
	wire		msb = tx_word_i[WORD_BITS-1];
	wire		same = format_reg_i[FMT_PHASE_BIT] == format_reg_i[FMT_POLARITY_BIT];
	// launch edge of the serial clock for the selected mode
	wire		launch = serial_clock_in_i != sclk_q && serial_clock_in_i == same;
	always_ff @(posedge clk_i) begin
		sclk_q <= serial_clock_in_i;
		launch_q <= {launch_q[2:0], launch};
	end
	sequence s_sel; $fell(cs_n) && !ctl; endsequence
	sequence s_take; tx_taken_o && !oe_n; endsequence
	property p_take; s_sel |-> ##[1:3] s_take; endproperty
	property p_msb; tx_taken_o |-> dq == $past(msb); endproperty
	property p_launch; !oe_n && $changed(dq) |-> tx_taken_o || (|launch_q); endproperty
	property p_rel; cs_n [*5] |-> oe_n; endproperty
	property p_ctl; ctl [*5] |-> !tx_taken_o && oe_n; endproperty
	property p_valid; rx_valid_o |-> cs_n && $past(cs_n) && !frame_error_o; endproperty
	property p_hold; $changed(rx_word_o) |-> rx_valid_o; endproperty
	property p_pulse; tx_taken_o || rx_valid_o |=> !tx_taken_o && !rx_valid_o; endproperty
	property p_busy; s_take |-> busy_o; endproperty
	property p_idle; cs_n [*3] |-> !busy_o; endproperty
	a_take: assert property (p_take) else $error("select not taken");
	a_msb: assert property (p_msb) else $error("first bit wrong");
	a_launch: assert property (p_launch) else $error("data off launch edge");
	a_rel: assert property (p_rel) else $error("line not released");
	a_ctl: assert property (p_ctl) else $error("active in controller mode");
	a_valid: assert property (p_valid) else $error("word out of place");
	a_hold: assert property (p_hold) else $error("word changed");
	a_pulse: assert property (p_pulse) else $error("pulse too long");
	a_busy: assert property (p_busy) else $error("busy missing in frame");
	a_idle: assert property (p_idle) else $error("busy while deselected");
endmodule
bind spi_peripheral_port spi_port_checker chk (.clk_i, .rst_n_i, .global_control_reg_i,
	.format_reg_i, .serial_clock_in_i, .chip_select_n_i, .tx_word_i, .dev_to_host_data_o,
	.dev_to_host_data_oe_n_o, .tx_taken_o, .rx_word_o, .rx_valid_o, .frame_error_o,
	.busy_o);
`default_nettype wire

/* File: spi_pin_sampler.sv */
// Purpose: registers the serial pins and reports the clock and select edges
// Assumes: pins are synchronous to clk_i
// Notes:   one register stage; edges compare it with the previous sample
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sampler
	import spi_periph_pkg::*;
(
	// clock and reset
	input  wire logic   clk_i,
	input  wire logic   rst_n_i,
	// pins
	input  wire pins_s  pins_i,
	// samples and edges
	output pins_s       now_o,
	output edges_s      edges_o
);

	pins_s now_q;
	pins_s prev_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			now_q  <= '{sclk: 1'b0, cs_n: 1'b1, data: 1'b0};
			prev_q <= '{sclk: 1'b0, cs_n: 1'b1, data: 1'b0};
		end else begin
			now_q  <= pins_i;
			prev_q <= now_q;
		end
	end

	assign now_o             = now_q;
	assign edges_o = '{
		sclk_rise: now_q.sclk & ~prev_q.sclk,
		sclk_fall: ~now_q.sclk & prev_q.sclk,
		cs_fall:   ~now_q.cs_n & prev_q.cs_n,
		cs_rise:   now_q.cs_n & ~prev_q.cs_n
	};

endmodule
`default_nettype wire

/* File: test_spi_peripheral_port.sv */
// Purpose: self-checking bench of the port
// Assumes: host model drives the serial pins
// Notes: driver queues words, monitor pops them
`timescale 1ns/1ps
`default_nettype none
module test_spi_peripheral_port
	import spi_periph_pkg::*;
;
	logic		clk_i, rst_n_i, sclk, cs_n, h2d, d2h, oe_n, rxv, ferr, perr, go, done, seen, busy;
	logic [31:0]	ctl, fmt, seed;
	logic [15:0]	tx, rx, hw, got;
	logic [17:0]	want;
	logic [17:0]	exp_q[$];
	logic [4:0]	nbits;
	logic [3:0]	half;
	logic [1:0]	mode;
	int		error_cnt = 0;
	int		total_checks = 0;
	spi_peripheral_port dut (.clk_i, .rst_n_i, .global_control_reg_i(ctl), .format_reg_i(fmt),
		.serial_clock_in_i(sclk), .chip_select_n_i(cs_n), .host_to_dev_data_i(h2d),
		.dev_to_host_data_o(d2h), .dev_to_host_data_oe_n_o(oe_n), .tx_word_i(tx),
		.tx_taken_o(), .rx_word_o(rx), .rx_valid_o(rxv), .busy_o(busy), .frame_error_o(ferr),
		.period_error_o(perr));
	spi_host_model host (.clk_i, .go_i(go), .mode_i(mode), .word_i(hw), .nbits_i(nbits),
		.half_i(half), .dev_data_i(d2h), .dev_oe_n_i(oe_n), .sclk_o(sclk), .cs_n_o(cs_n),
		.data_o(h2d), .got_o(got), .done_o(done));
	initial begin
		clk_i = 1'h0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic check(input logic [17:0] s, input logic [17:0] e);
		total_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic test_done();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		if (rst_n_i && (rxv === 1'h1 || ferr === 1'h1)) begin
			want = exp_q.size() ? exp_q.pop_front() : 18'h3FFFF;
			check({rxv, ferr, rxv ? rx : 16'h0000}, want);
		end
		if (perr === 1'h1) seen <= 1'h1;
	end
	task automatic frame(input logic [1:0] m, input logic [4:0] nb, input logic [3:0] hp,
		input logic [7:0] ps, input logic c);
		int n;
		{fmt, ctl} <= {14'h0000, m, ps, 8'h00, 31'h00000000, c};
		{tx, hw} <= {16'($urandom), 16'($urandom)};
		{mode, nbits, half, seen} <= {m, nb, hp, 1'h0};
		repeat (4) @(posedge clk_i);
		if (!c) exp_q.push_back(nb == 5'h10 ? {2'h2, hw} : 18'h10000);
		go <= 1'h1;
		for (n = 0; n < 2000 && done !== 1'h1; n++) @(posedge clk_i);
		check({17'h00000, n == 2000}, 18'h00000);
		check({17'h00000, busy}, {17'h00000, !c});
		go <= 1'h0;
		repeat (8) @(posedge clk_i);
		check({17'h00000, busy}, 18'h00000);
		check(18'(exp_q.size()), 18'h00000);
		check({17'h00000, seen}, {17'h00000, hp == 4'h2});
		if (!c && nb == 5'h10 && hp == 4'h4) check({2'h0, got}, {2'h0, tx});
	endtask
	initial begin
		{rst_n_i, go, seen, ctl, fmt, tx, hw} = 99'h0;
		{nbits, half, mode} = 11'h000;
		seed = $urandom(32'h7a21);
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		// every clock mode twice, two rounds of modes 0 to 3 in turn
		for (int m = 0; m < 8; m++) frame(2'(m), 5'h10, 4'h4, 8'($urandom_range(3)), 1'h0);
		// short word, controller mode, recovery, fast clock
		frame(2'h1, 5'h0F, 4'h4, 8'h00, 1'h0);
		frame(2'h2, 5'h10, 4'h4, 8'h01, 1'h1);
		frame(2'h3, 5'h10, 4'h4, 8'h03, 1'h0);
		frame(2'h0, 5'h10, 4'h2, 8'h05, 1'h0);
		test_done();
	end
	initial begin
		#200us;
		error_cnt++;
		test_done();
	end
endmodule
`default_nettype wire
